// ==== common/pwmot_pkg.sv ====
package pwmot_pkg;

    // ****************************************************************
    // register map (byte offsets, one 32-bit word each)
    // ****************************************************************
    localparam logic [7:0] MODE_OFS = 8'h00;
    localparam logic [7:0] PINST_OFS = 8'h04;
    localparam logic [7:0] CTRL_OFS = 8'h08;
    localparam logic [7:0] CNT_OFS = 8'h0c;
    localparam logic [7:0] RELOAD_OFS = 8'h10;
    localparam logic [7:0] CMPRLD_OFS = 8'h14;
    localparam logic [7:0] CMP_OFS = 8'h18;
    localparam logic [7:0] ISTAT_OFS = 8'h1c;
    localparam logic [7:0] ICLR_OFS = 8'h20;
    localparam logic [7:0] IEN_OFS = 8'h24;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SWTRIG_BIT = 1;
    localparam int PIN_LEVEL_BIT = 0;
    localparam int EV_TC_BIT = 0;
    localparam int EV_MATCH_BIT = 1;
    localparam int EV_W = 2;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_TOP = 16'hffff;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [6:0] DIV8_MASK = 7'h07;
    localparam logic [6:0] DIV32_MASK = 7'h1f;
    localparam logic [6:0] DIV128_MASK = 7'h7f;

    // ****************************************************************
    // mode encodings
    // ****************************************************************
    localparam logic [1:0] OT_NONE = 2'b00;
    localparam logic [1:0] OT_CMP = 2'b01;
    localparam logic [1:0] OT_TOGGLE = 2'b10;
    localparam logic [1:0] OT_REAL = 2'b11;
    localparam logic [2:0] GT_OFF = 3'b000;
    localparam logic [2:0] GT_RISE = 3'b001;
    localparam logic [2:0] GT_FALL = 3'b010;
    localparam logic [2:0] GT_BOTH = 3'b011;
    localparam logic [2:0] GT_GATE_LO = 3'b110;
    localparam logic [2:0] GT_GATE_HI = 3'b111;
    localparam logic [2:0] CS_PCLK = 3'b000;
    localparam logic [2:0] CS_DIV8 = 3'b001;
    localparam logic [2:0] CS_DIV32 = 3'b010;
    localparam logic [2:0] CS_DIV128 = 3'b011;
    localparam logic [2:0] CS_EXT = 3'b110;

    // mode word, msb first: bit 16 of the map is data bit 15
    typedef struct packed {
        logic timer_kind_select;
        logic terminal_count_repeat_select;
        logic terminal_condition_select;
        logic [1:0] output_type_select;
        logic [2:0] gate_trigger_select;
        logic [2:0] unused;
        logic output_polarity_select;
        logic count_direction_select;
        logic [2:0] count_source_select;
    } pwmot_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pwmot_bus_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_COUNT = 2'b11
    } pwmot_state_t;

    // edge of the pin that the gate/trigger field picks
    function automatic logic pwmot_pin_edge(
        input logic [2:0] gts,
        input logic prev,
        input logic cur
    );
        logic hit;
        hit = 1'b0;
        case (gts)
            GT_RISE: hit = cur & ~prev;
            GT_FALL: hit = prev & ~cur;
            GT_BOTH: hit = cur ^ prev;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : pwmot_pin_edge

endpackage : pwmot_pkg

// ==== hdl/pwmot_count_src.sv ====
`timescale 1ns/100ps
module pwmot_count_src (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [2:0] count_source_select,
    input wire logic [2:0] gate_trigger_select,
    input wire logic pin_sync,
    output logic tick_q,
    output logic trig_edge_q
);
    import pwmot_pkg::*;

    logic [6:0] div_q;
    logic pin_prev_q;
    logic pin_edge;

    // ****************************************************************
    // prescaler
    // ****************************************************************
    // free-running divider; phase is not reset on a source change
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            div_q <= 7'h00;
        else
            div_q <= div_q + 7'h01;
    end

    // pin history for edge detection, fed from the second sync stage
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_prev_q <= 1'b0;
        else
            pin_prev_q <= pin_sync;
    end

    assign pin_edge = pwmot_pin_edge(gate_trigger_select, pin_prev_q,
                                     pin_sync);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            tick_q <= 1'b0;
        else
        begin
            case (count_source_select)
                CS_PCLK: tick_q <= 1'b1;
                CS_DIV8: tick_q <= (div_q[2:0] == DIV8_MASK[2:0]);
                CS_DIV32: tick_q <= (div_q[4:0] == DIV32_MASK[4:0]);
                CS_DIV128: tick_q <= (div_q == DIV128_MASK);
                // pin edge chosen by gate/trigger field
                CS_EXT: tick_q <= pin_edge;
                default: tick_q <= 1'b0; // reserved codes: no count
            endcase
        end
    end

    // trigger edge, aligned with the tick path
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            trig_edge_q <= 1'b0;
        else
            trig_edge_q <= pin_edge;
    end

endmodule : pwmot_count_src

// ==== hdl/pwmot_timer.sv ====
// Summary of operation
// - timer select 1 makes output timer
// - bit 17 picks repeat or single count
// - terminal at 0000/ffff or by compare
// - output type 01 drives compare waveform
// - gate/trigger field decodes edges and gates
// - bit 27 inverts output polarity
// - bit 28 picks down or up count
// - source is pclk divided or pin
// - irq and dma at tick after terminal
// - 16-bit counter, reload, compare, compare reload
// - one-shot clears enable unless trigger mode
// - one-shot pulse started by software or pin
// - up count gives delayed output assertion
// - pwm reloads count and compare each period
// - other output codes none, toggle, port
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module pwmot_timer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire pwmot_pkg::pwmot_bus_req_t bus_req,
    output logic [31:0] rdata_q,
    input wire logic trigger_count_input_pin,
    output logic waveform_output_pin_o_q,
    output logic waveform_output_pin_oe_q,
    output logic irq_q,
    output logic dma_req_q
);
    import pwmot_pkg::*;

    // ****************************************************************
    // declarations
    // ****************************************************************
    pwmot_mode_t mode_q;
    pwmot_state_t state_q, state_d;
    logic pin_s1_q, pin_s2_q, en_q, swtrig;
    logic [15:0] cnt_q, reload_q, cmp_q, cmp_reload_q;
    logic pin_level_q, level_q;
    logic [EV_W-1:0] istat_q, ien_q, ev;
    logic tick, trig_edge, trig_mode, gate_ok, count_tick;
    logic tc_now, match_now, expire, start, hw_disable;
    logic wr_mode, wr_pin, wr_ctrl, wr_cnt;

    // ****************************************************************
    // pin input synchroniser
    // ****************************************************************
    // the first stage feeds only the second one
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= trigger_count_input_pin;
            pin_s2_q <= pin_s1_q;
        end
    end

    // pin sampled at pclk, so edges faster than pclk/2 are lost
    pwmot_count_src u_count_src (
        .core_clk (core_clk),
        .rst_n (rst_n),
        .count_source_select (mode_q.count_source_select),
        .gate_trigger_select (mode_q.gate_trigger_select),
        .pin_sync (pin_s2_q),
        .tick_q (tick),
        .trig_edge_q (trig_edge)
    );

    // ****************************************************************
    // write decode
    // ****************************************************************
    assign wr_mode = bus_req.wr && (bus_req.addr == MODE_OFS);
    assign wr_pin = bus_req.wr && (bus_req.addr == PINST_OFS);
    assign wr_ctrl = bus_req.wr && (bus_req.addr == CTRL_OFS);
    assign wr_cnt = bus_req.wr && (bus_req.addr == CNT_OFS);
    assign swtrig = wr_ctrl && bus_req.wdata[CTRL_SWTRIG_BIT];
    // mode register; reserved bits are held at zero
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            mode_q <= MODE_RST;
        else if (wr_mode)
        begin
            mode_q <= bus_req.wdata[15:0];
            mode_q.unused <= 3'b000;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reload_q <= CNT_RST;
            cmp_reload_q <= CNT_RST;
        end
        else if (bus_req.wr)
        begin
            if (bus_req.addr == RELOAD_OFS)
                reload_q <= bus_req.wdata[15:0];
            if (bus_req.addr == CMPRLD_OFS)
                cmp_reload_q <= bus_req.wdata[15:0];
        end
    end
    // interrupt enable register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            ien_q <= '0;
        else if (bus_req.wr && (bus_req.addr == IEN_OFS))
            ien_q <= bus_req.wdata[EV_W-1:0];
    end

    // ****************************************************************
    // gate, trigger and tick qualification
    // ****************************************************************
    // trigger codes start the count, gate codes hold it
    // with the pin as count source the field picks the edge instead
    assign trig_mode = (mode_q.count_source_select != CS_EXT) &&
        ((mode_q.gate_trigger_select == GT_RISE) ||
         (mode_q.gate_trigger_select == GT_FALL) ||
         (mode_q.gate_trigger_select == GT_BOTH));
    always_comb
    begin
        gate_ok = 1'b1;
        if (mode_q.count_source_select != CS_EXT)
            case (mode_q.gate_trigger_select)
                GT_GATE_LO: gate_ok = ~pin_s2_q;
                GT_GATE_HI: gate_ok = pin_s2_q;
                default: gate_ok = 1'b1;
            endcase
    end
    // only an output timer counts here
    assign count_tick = tick && gate_ok && (state_q == ST_COUNT) &&
        en_q && mode_q.timer_kind_select;
    // terminal condition on the present count
    always_comb
    begin
        if (!mode_q.terminal_condition_select)
            tc_now = mode_q.count_direction_select ?
                (cnt_q == CNT_TOP) : (cnt_q == CNT_BOTTOM);
        else if (mode_q.count_direction_select)
            tc_now = (cnt_q >= cmp_q);
        else
            tc_now = (cnt_q < cmp_q);
    end

    assign match_now = (cnt_q == cmp_q);
    // terminal takes effect at the following source edge
    assign expire = count_tick && tc_now;
    // hardware clears enable after a one-shot, not in trigger mode
    assign hw_disable = expire && mode_q.terminal_count_repeat_select &&
        !trig_mode;

    // ****************************************************************
    // enable bit and run state
    // ****************************************************************
    // a software write wins over the hardware clear in one cycle
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            en_q <= 1'b0;
        else if (wr_ctrl)
            en_q <= bus_req.wdata[CTRL_EN_BIT];
        else if (hw_disable)
            en_q <= 1'b0;
    end

    // start by enable, software trigger or pin edge
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (en_q && mode_q.timer_kind_select)
                    state_d = trig_mode ? ST_ARMED : ST_COUNT;
            ST_ARMED:
                if (!en_q)
                    state_d = ST_IDLE;
                else if (trig_edge || swtrig)
                    state_d = ST_COUNT;
            ST_COUNT:
                if (!en_q)
                    state_d = ST_IDLE;
                else if (expire && mode_q.terminal_count_repeat_select)
                    state_d = trig_mode ? ST_ARMED : ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end
    assign start = (state_d == ST_COUNT) && (state_q != ST_COUNT);

    // ****************************************************************
    // counter and compare
    // ****************************************************************
    // 16-bit counter, loaded from reload at start and period end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= CNT_RST;
        else if (wr_cnt)
            cnt_q <= bus_req.wdata[15:0];
        else if (start)
            cnt_q <= reload_q;
        else if (expire)
            cnt_q <= reload_q;
        else if (count_tick)
            if (mode_q.count_direction_select)
                cnt_q <= cnt_q + 16'h0001;
            else
                cnt_q <= cnt_q - 16'h0001;
    end

    // compare taken from its reload register each period
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            cmp_q <= CNT_RST;
        else if (start || expire)
            cmp_q <= cmp_reload_q;
    end

    // ****************************************************************
    // waveform level
    // ****************************************************************
    // software value of the pin status bit, used by real port output
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_level_q <= 1'b0;
        else if (wr_pin)
            pin_level_q <= bus_req.wdata[PIN_LEVEL_BIT];
    end

    // writing the status bit forces the level
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            level_q <= 1'b0;
        else if (wr_pin)
            level_q <= bus_req.wdata[PIN_LEVEL_BIT];
        else if (count_tick)
            case (mode_q.output_type_select)
                OT_CMP:
                    // back at terminal, set on match
                    if (expire)
                        level_q <= 1'b0;
                    // up count with compare delays the rise
                    else if (match_now)
                        level_q <= 1'b1;
                OT_TOGGLE:
                    if (expire)
                        level_q <= ~level_q;
                OT_REAL:
                    if (expire)
                        level_q <= pin_level_q;
                default: level_q <= level_q;
            endcase
    end

    // pin drive; a stop mid-count leaves the last level standing
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waveform_output_pin_o_q <= 1'b0;
            waveform_output_pin_oe_q <= 1'b0;
        end
        else
        begin
            // polarity, not applied to real port data
            if (mode_q.output_type_select == OT_REAL)
                waveform_output_pin_o_q <= level_q;
            else
                waveform_output_pin_o_q <= level_q ^
                    mode_q.output_polarity_select;
            // code 00 leaves the pin undriven
            waveform_output_pin_oe_q <= mode_q.timer_kind_select &&
                (mode_q.output_type_select != OT_NONE);
        end
    end

    // ****************************************************************
    // events, interrupt and dma
    // ****************************************************************
    assign ev[EV_TC_BIT] = expire;
    assign ev[EV_MATCH_BIT] = count_tick && match_now && !expire;
    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            istat_q <= '0;
        else if (bus_req.wr && (bus_req.addr == ICLR_OFS))
            istat_q <= (istat_q & ~bus_req.wdata[EV_W-1:0]) | ev;
        else
            istat_q <= istat_q | ev;
    end
    // interrupt level and one-cycle dma request
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_q <= 1'b0;
            dma_req_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(istat_q & ien_q);
            dma_req_q <= expire;
        end
    end

    // ****************************************************************
    // read port
    // ****************************************************************
    // data one cycle after the strobe, zero for unmapped addresses
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 32'h0000_0000;
        else if (bus_req.rd)
        begin
            case (bus_req.addr)
                MODE_OFS: rdata_q <= {16'h0000, mode_q};
                PINST_OFS: rdata_q <= {31'h0, level_q};
                CTRL_OFS: rdata_q <= {31'h0, en_q};
                CNT_OFS: rdata_q <= {16'h0000, cnt_q};
                RELOAD_OFS: rdata_q <= {16'h0000, reload_q};
                CMPRLD_OFS: rdata_q <= {16'h0000, cmp_reload_q};
                CMP_OFS: rdata_q <= {16'h0000, cmp_q};
                ISTAT_OFS: rdata_q <= {30'h0, istat_q};
                IEN_OFS: rdata_q <= {30'h0, ien_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
        else
            rdata_q <= 32'h0000_0000;
    end

endmodule : pwmot_timer

// ==== test/pwmot_asserts.sv ====
`timescale 1ns/100ps
module pwmot_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire pwmot_pkg::pwmot_bus_req_t bus_req,
    input wire logic [31:0] rdata_q,
    input wire logic trigger_count_input_pin,
    input wire logic waveform_output_pin_o_q,
    input wire logic waveform_output_pin_oe_q,
    input wire logic irq_q,
    input wire logic dma_req_q
);
    import pwmot_pkg::*;
    pwmot_mode_t mode_q;
    logic [EV_W-1:0] ien_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // shadows from bus writes
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= '0;
            ien_q <= '0;
        end
        else if (bus_req.wr && bus_req.addr == MODE_OFS)
            mode_q <= pwmot_mode_t'(bus_req.wdata[15:0]);
        else if (bus_req.wr && bus_req.addr == IEN_OFS)
            ien_q <= bus_req.wdata[EV_W-1:0];
    end

    // ********
    // properties
    // ********
    property p_rd_idle;
        !bus_req.rd |=> rdata_q == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    property p_unmapped;
        bus_req.rd && bus_req.addr > IEN_OFS |=> rdata_q == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_mode_back;
        bus_req.wr && bus_req.addr == MODE_OFS ##2
        bus_req.rd && bus_req.addr == MODE_OFS
        |=> rdata_q == ($past(bus_req.wdata, 3) & 32'hff1f);
    endproperty
    a_mode_back: assert property (p_mode_back)
        else $error("mode readback wrong");
    property p_reload_back;
        bus_req.wr && bus_req.addr == RELOAD_OFS ##2
        bus_req.rd && bus_req.addr == RELOAD_OFS
        |=> rdata_q == {16'h0, $past(bus_req.wdata[15:0], 3)};
    endproperty
    a_reload_back: assert property (p_reload_back)
        else $error("reload readback wrong");
    property p_irq_fall;
        $fell(irq_q) |-> $past(bus_req.wr) || $past(bus_req.wr, 2)
            || $past(bus_req.wr, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq dropped without a write");
    property p_dma_irq;
        dma_req_q && ien_q[EV_TC_BIT] |-> ##[0:2] irq_q;
    endproperty
    a_dma_irq: assert property (p_dma_irq)
        else $error("expiry did not raise irq");
    property p_irq_mask;
        (ien_q == '0) [*3] |-> !irq_q;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("irq while all masked");
    // one expiry may still flush
    property p_timer_kind_select_off;
        (!mode_q.timer_kind_select) [*4] |-> !dma_req_q;
    endproperty
    a_timer_kind_select_off: assert property (p_timer_kind_select_off)
        else $error("expiry with timer select off");

    c_dma: cover property (dma_req_q);
    c_irq: cover property ($rose(irq_q));
    c_wave: cover property ($rose(waveform_output_pin_o_q));
endmodule : pwmot_asserts

bind pwmot_timer pwmot_asserts pwmot_asserts_i (
    .core_clk, .rst_n, .bus_req, .rdata_q, .trigger_count_input_pin,
    .waveform_output_pin_o_q, .waveform_output_pin_oe_q, .irq_q,
    .dma_req_q
);

// ==== test/pwmot_pin_model.sv ====
`timescale 1ns/100ps
module pwmot_pin_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [3:0] n_pulses,
    output logic pin
);
    logic [4:0] left_q;

    // one level change a cycle
    // worst legal rate
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            left_q <= 5'h0;
        else if (go)
            left_q <= {n_pulses, 1'h0};
        else if (left_q != 5'h0)
            left_q <= left_q - 5'h1;
    end

    // odd counts high, idles low
    assign pin = left_q[0];
endmodule : pwmot_pin_model

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    import pwmot_pkg::*;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    pwmot_bus_req_t req = '0;
    logic [31:0] rdata_q;
    logic pin, o_q, oe_q, irq_q, dma_q;
    logic go = 1'h0;
    logic [3:0] npl = 4'h1;
    logic [31:0] n;
    logic [15:0] m;
    int n_errors = 0;
    int num_checks = 0;
    logic [2:0] cs_t[7] = '{CS_PCLK, CS_DIV8, CS_DIV32, CS_DIV128,
        CS_PCLK, CS_PCLK, CS_PCLK};
    logic [15:0] rl_t[7] = '{16'h5, 16'h1, 16'h1, 16'h1, 16'hfffd,
        16'h5, 16'h0};
    logic [15:0] cp_t[7] = '{16'h2, 16'h0, 16'h0, 16'h0, 16'h0,
        16'h2, 16'h3};
    int ex_t[7] = '{6, 16, 64, 256, 3, 5, 4};
    logic [6:0] up_v = 7'h50;
    logic [6:0] tcc_v = 7'h60;

    // 20 MHz core clock
    always #25 core_clk = ~core_clk;

    pwmot_timer pwmot_timer_i (.core_clk(core_clk), .rst_n(rst_n),
        .bus_req(req), .rdata_q(rdata_q), .trigger_count_input_pin(pin),
        .waveform_output_pin_o_q(o_q), .waveform_output_pin_oe_q(oe_q),
        .irq_q(irq_q), .dma_req_q(dma_q));
    pwmot_pin_model pwmot_pin_model_i (.core_clk(core_clk),
        .rst_n(rst_n), .go(go), .n_pulses(npl), .pin(pin));

    // ********
    // tasks
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        req <= '{a, d, 1'h1, 1'h0};
        @(posedge core_clk);
        req.wr <= 1'h0;
    endtask : wr

    // data valid one cycle after strobe
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        req <= '{a, 32'h0, 1'h0, 1'h1};
        @(posedge core_clk);
        req.rd <= 1'h0;
        #1;
        chk(rdata_q, exp);
    endtask : rc

    function automatic logic [15:0] md(input logic [2:0] k,
        input logic [1:0] ot, input logic [2:0] gt, input logic [1:0] pu,
        input logic [2:0] cs);
        md = {k, ot, gt, 3'h0, pu, cs};
    endfunction : md

    task automatic run(input logic [15:0] r, input logic [15:0] c);
        wr(CTRL_OFS, 32'h0);
        wr(MODE_OFS, {16'h0, m});
        wr(RELOAD_OFS, {16'h0, r});
        wr(CMPRLD_OFS, {16'h0, c});
        wr(CTRL_OFS, 32'h1);
    endtask : run

    // cycles to next expiry, 0 if none in 600
    task automatic wdma(output logic [31:0] c);
        c = 32'h0;
        do
        begin
            @(posedge core_clk);
            #1;
            c++;
        end while (dma_q !== 1'h1 && c < 32'h258);
        if (dma_q !== 1'h1)
            c = 32'h0;
    endtask : wdma

    task automatic hi(input int k, output logic [31:0] h);
        h = 32'h0;
        repeat (k)
        begin
            @(posedge core_clk);
            #1;
            h = h + o_q;
        end
    endtask : hi

    task automatic pulse(input logic [3:0] k);
        @(posedge core_clk);
        go <= 1'h1;
        npl <= k;
        @(posedge core_clk);
        go <= 1'h0;
    endtask : pulse

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    // ********
    // tests
    // ********
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'h1;
        rc(MODE_OFS, 32'h0);
        rc(ISTAT_OFS, 32'h0);
        wr(8'h28, 32'hffffffff);
        rc(8'h28, 32'h0);
        wr(MODE_OFS, 32'hffffffff);
        rc(MODE_OFS, 32'hff1f);
        wr(RELOAD_OFS, 32'hffff1234);
        rc(RELOAD_OFS, 32'h1234);
        for (int i = 0; i < 7; i++)
        begin
            m = md({2'h2, tcc_v[i]}, OT_CMP, GT_OFF, {1'h0, up_v[i]}, cs_t[i]);
            run(rl_t[i], cp_t[i]);
            wdma(n);
            wdma(n);
            chk(n, ex_t[i]);
        end
        // duty and polarity, late rise counting up
        wr(IEN_OFS, 32'h1);
        for (int p = 0; p < 3; p++)
        begin
            m = md(3'h4, OT_CMP, GT_OFF, {p[0], p[1]}, CS_PCLK);
            run(p[1] ? 16'hfffa : 16'h5, p[1] ? 16'hfffd : 16'h2);
            wdma(n);
            hi(12, n);
            chk(n, p[0] ? 32'h8 : 32'h4);
        end
        rc(CMP_OFS, 32'hfffd);
        chk({31'h0, irq_q}, 32'h1);
        rc(ISTAT_OFS, 32'h3);
        wr(CTRL_OFS, 32'h0);
        wr(ICLR_OFS, 32'h3);
        rc(ISTAT_OFS, 32'h0);
        chk({31'h0, irq_q}, 32'h0);
        wr(IEN_OFS, 32'h0);
        wr(CTRL_OFS, 32'h1);
        wdma(n);
        chk({31'h0, irq_q}, 32'h0);
        wr(IEN_OFS, 32'h1);
        rc(ISTAT_OFS, 32'h3);
        chk({31'h0, irq_q}, 32'h1);
        m = md(3'h0, OT_CMP, GT_OFF, 2'h0, CS_PCLK);
        run(16'h3, 16'h1);
        wdma(n);
        chk(n, 32'h0);
        m = md(3'h6, OT_CMP, GT_OFF, 2'h0, CS_PCLK);
        run(16'h3, 16'h1);
        wdma(n);
        chk({31'h0, n != 32'h0}, 32'h1);
        wdma(n);
        chk(n, 32'h0);
        rc(CTRL_OFS, 32'h0);
        for (int g = 1; g < 4; g++)
        begin
            m = md(3'h6, OT_CMP, 3'(g), 2'h0, CS_PCLK);
            run(16'h3, 16'h1);
            wdma(n);
            chk(n, 32'h0);
            pulse(4'h1);
            wdma(n);
            chk({31'h0, n != 32'h0}, 32'h1);
            rc(CTRL_OFS, 32'h1);
        end
        wr(CTRL_OFS, 32'h3);
        wdma(n);
        chk({31'h0, n != 32'h0}, 32'h1);
        m = md(3'h4, OT_CMP, GT_RISE, 2'h0, CS_EXT);
        run(16'h1, 16'h0);
        pulse(4'h1);
        wdma(n);
        chk(n, 32'h0);
        pulse(4'h1);
        wdma(n);
        chk({31'h0, n != 32'h0}, 32'h1);
        wr(CTRL_OFS, 32'h0);
        wr(PINST_OFS, 32'h1);
        rc(PINST_OFS, 32'h1);
        chk({31'h0, o_q}, 32'h1);
        chk({31'h0, oe_q}, 32'h1);
        m = md(3'h4, OT_CMP, GT_OFF, 2'h2, CS_PCLK);
        wr(MODE_OFS, {16'h0, m});
        rc(PINST_OFS, 32'h1);
        chk({31'h0, o_q}, 32'h0);
        wr(MODE_OFS, 32'h8000);
        rc(MODE_OFS, 32'h8000);
        chk({31'h0, oe_q}, 32'h0);
        m = md(3'h4, OT_TOGGLE, GT_OFF, 2'h0, CS_PCLK);
        run(16'h1, 16'h0);
        wdma(n);
        hi(8, n);
        chk(n, 32'h4);
        conclude();
    end

    // watchdog with ample margin
    initial
    begin
        repeat (60000) @(posedge core_clk);
        n_errors++;
        conclude();
    end
endmodule : tb_top
